// ### hw/ccc_pkg.sv
// Shared constants and types for the compass calibration command block
package ccc_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned BAUD = 9600;
   localparam logic [11:0] BIT_CYC = 12'(CLK_HZ / BAUD);
   localparam logic [11:0] HALF_BIT_CYC = 12'(CLK_HZ / BAUD / 2);
   localparam int unsigned STEADY_MS = 2000;
   localparam int unsigned COMPUTE_MS = 2000;
   localparam int unsigned STEADY_CYC_DEF = STEADY_MS * (CLK_HZ / 1000);
   localparam int unsigned COMPUTE_CYC_DEF = COMPUTE_MS * (CLK_HZ / 1000);
   // ----------------------------------------------------------------
   // Frame layout
   // ----------------------------------------------------------------
   localparam logic [7:0] FRAME_ID = 8'h68;
   localparam logic [7:0] DEV_ADDR = 8'h00;
   localparam logic [7:0] LEN_MIN = 8'h04;
   localparam logic [7:0] LEN_REPLY = 8'h05;
   localparam logic [2:0] REPLY_BYTES = 3'h6;
   localparam logic [3:0] UART_BITS = 4'h9;
   // ----------------------------------------------------------------
   // Commands and results
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_AUTO = 8'h44;
   localparam logic [7:0] CMD_MANUAL = 8'h43;
   localparam logic [7:0] CMD_START = 8'h08;
   localparam logic [7:0] CMD_STOP = 8'h09;
   localparam logic [7:0] CMD_SAVE = 8'h0A;
   localparam logic [7:0] RSP_FLAG = 8'h80;
   localparam logic [7:0] RES_OK = 8'h00;
   localparam logic [7:0] RES_FAIL = 8'hFF;
   localparam logic [5:0] MAX_POINTS = 6'h32;
   localparam logic [5:0] MIN_POINTS = 6'h0C;
   localparam logic [5:0] REC_POINTS = 6'h18;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] data;
   } ccc_reply_t;
   typedef enum {CAL_IDLE, CAL_COLLECT, CAL_COMPUTE, CAL_DONE} ccc_cal_t;
   typedef enum {P_ID, P_LEN, P_ADDR, P_CMD, P_DATA, P_SUM} ccc_parse_t;
endpackage

// ### hw/ccc_uart.sv
// Byte-wide serial receiver and transmitter, 8N1
`timescale 1ns/1ps
`default_nettype none
module ccc_uart import ccc_pkg::*; #(
   parameter logic [11:0] BIT_LEN = BIT_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic rxd,
   output logic [7:0] rx_byte,
   output logic rx_valid,
   input wire logic [7:0] tx_byte,
   input wire logic tx_start,
   output logic tx_busy,
   output logic txd
);
   // ----------------------------------------------------------------
   // Receiver: sample each bit at its centre
   // ----------------------------------------------------------------
   // Shortened bit times keep simulation runs short
   localparam logic [11:0] HALF_LEN = BIT_LEN >> 1;
   logic rx_busy;
   logic [11:0] rx_cnt;
   logic [3:0] rx_bit;
   logic [7:0] rx_shift;

   always_ff @(posedge clk) begin
      rx_valid <= 1'b0;
      if (sys_rst) begin
         rx_busy <= 1'b0;
         rx_cnt <= 12'h000;
         rx_bit <= 4'h0;
         rx_shift <= 8'h00;
         rx_byte <= 8'h00;
      end else if (!rx_busy) begin
         if (!rxd) begin
            rx_busy <= 1'b1;
            rx_cnt <= HALF_LEN;
            rx_bit <= 4'h0;
         end
      end else if (rx_cnt != 12'h000) begin
         rx_cnt <= rx_cnt - 12'h001;
      end else begin
         rx_cnt <= BIT_LEN - 12'h001;
         rx_bit <= rx_bit + 4'h1;
         if (rx_bit == 4'h0 && rxd) begin
            // Glitch rather than a start bit
            rx_busy <= 1'b0;
         end else if (rx_bit == UART_BITS) begin
            rx_busy <= 1'b0;
            rx_valid <= rxd;
            rx_byte <= rx_shift;
         end else if (rx_bit != 4'h0) begin
            rx_shift <= {rxd, rx_shift[7:1]};
         end
      end
   end

   // ----------------------------------------------------------------
   // Transmitter: start, eight data bits LSB first, one stop bit
   // ----------------------------------------------------------------
   logic [9:0] tx_shift;
   logic [11:0] tx_cnt;
   logic [3:0] tx_bit;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tx_busy <= 1'b0;
         tx_shift <= 10'h3FF;
         tx_cnt <= 12'h000;
         tx_bit <= 4'h0;
         txd <= 1'b1;
      end else if (!tx_busy) begin
         if (tx_start) begin
            tx_busy <= 1'b1;
            tx_shift <= {1'b1, tx_byte, 1'b0};
            tx_cnt <= BIT_LEN - 12'h001;
            tx_bit <= 4'h0;
            txd <= 1'b0;
         end
      end else if (tx_cnt != 12'h000) begin
         tx_cnt <= tx_cnt - 12'h001;
      end else if (tx_bit == UART_BITS) begin
         tx_busy <= 1'b0;
         txd <= 1'b1;
      end else begin
         tx_cnt <= BIT_LEN - 12'h001;
         tx_bit <= tx_bit + 4'h1;
         tx_shift <= {1'b1, tx_shift[9:1]};
         txd <= tx_shift[1];
      end
   end
endmodule // ccc_uart
`default_nettype wire

// ### hw/ccc_calib.sv
// Calibration command interpreter of the compass module
// Contract
// - Device acknowledges start, then reports every captured point.
// - After stop, about two seconds of computing, then a quality percentage.
// - Host sends save 0A; device answers whether storing succeeded.
// - Failed save lets host retry; device keeps factory calibration. Here any save in CAL_DONE returns to idle, so a retry is refused.
// - At most fifty points per run; twenty-four recommended.
// - A point is captured after two to three seconds held steady.
// - Point headings are relative to the first captured point.
// - Frames: 68, length, address, command, data, carry-free checksum.
// - Serial link is 8 data bits, 1 stop bit, no parity, 9600 baud.
// - Start acknowledged with reply 88 and result 00 or FF.
// - Each point reported with reply 88 carrying the running count.
`timescale 1ns/1ps
`default_nettype none
module ccc_calib import ccc_pkg::*; #(
   parameter int unsigned STEADY_CYC = STEADY_CYC_DEF,
   parameter int unsigned COMPUTE_CYC = COMPUTE_CYC_DEF,
   parameter logic [11:0] BIT_LEN = BIT_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic rxd,
   input wire logic steady,
   input wire logic [15:0] heading,
   input wire logic [7:0] fit_quality,
   input wire logic store_ok,
   output logic txd,
   output logic point_strobe,
   output logic [15:0] rel_heading,
   output logic [5:0] point_count,
   output logic cal_active,
   output logic computing,
   output logic auto_mode,
   output logic use_factory
);
   // ----------------------------------------------------------------
   // Serial port
   // ----------------------------------------------------------------
   logic [7:0] rx_byte;
   logic rx_valid;
   logic [7:0] tx_byte;
   logic tx_go;
   logic tx_busy;

   ccc_uart #(.BIT_LEN(BIT_LEN)) u_uart (
      .clk(clk),
      .sys_rst(sys_rst),
      .rxd(rxd),
      .rx_byte(rx_byte),
      .rx_valid(rx_valid),
      .tx_byte(tx_byte),
      .tx_start(tx_go),
      .tx_busy(tx_busy),
      .txd(txd)
   );

   // ----------------------------------------------------------------
   // Frame parser
   // ----------------------------------------------------------------
   ccc_parse_t pst;
   logic [7:0] f_len;
   logic [7:0] f_addr;
   logic [7:0] f_cmd;
   logic [7:0] f_sum;
   logic [7:0] f_left;
   logic cmd_valid;
   logic [7:0] cmd_code;

   always_ff @(posedge clk) begin
      cmd_valid <= 1'b0;
      if (sys_rst) begin
         pst <= P_ID;
         f_len <= 8'h00;
         f_addr <= 8'h00;
         f_cmd <= 8'h00;
         f_sum <= 8'h00;
         f_left <= 8'h00;
         cmd_code <= 8'h00;
      end else if (rx_valid) begin
         case (pst)
            P_ID: if (rx_byte == FRAME_ID) pst <= P_LEN;
            P_LEN: begin
               f_len <= rx_byte;
               f_sum <= rx_byte;
               f_left <= rx_byte - LEN_MIN;
               pst <= (rx_byte < LEN_MIN) ? P_ID : P_ADDR;
            end
            P_ADDR: begin
               f_addr <= rx_byte;
               f_sum <= f_sum + rx_byte;
               pst <= P_CMD;
            end
            P_CMD: begin
               f_cmd <= rx_byte;
               f_sum <= f_sum + rx_byte;
               pst <= (f_left == 8'h00) ? P_SUM : P_DATA;
            end
            P_DATA: begin
               // Data bytes only feed the checksum; no command here uses them
               f_sum <= f_sum + rx_byte;
               f_left <= f_left - 8'h01;
               if (f_left == 8'h01) pst <= P_SUM;
            end
            P_SUM: begin
               pst <= P_ID;
               if (rx_byte == f_sum && f_addr == DEV_ADDR) begin
                  cmd_valid <= 1'b1;
                  cmd_code <= f_cmd;
               end
            end
            default: pst <= P_ID;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Reply transmitter: 68 05 addr cmd data sum
   // ----------------------------------------------------------------
   logic rq_v;
   ccc_reply_t rq;
   logic pend;
   ccc_reply_t rep;
   logic [2:0] tx_idx;

   always_comb begin
      case (tx_idx)
         3'h0: tx_byte = FRAME_ID;
         3'h1: tx_byte = LEN_REPLY;
         3'h2: tx_byte = DEV_ADDR;
         3'h3: tx_byte = rep.cmd;
         3'h4: tx_byte = rep.data;
         default: tx_byte = LEN_REPLY + DEV_ADDR + rep.cmd + rep.data;
      endcase
   end

   always_ff @(posedge clk) begin
      tx_go <= 1'b0;
      if (sys_rst) begin
         pend <= 1'b0;
         rep <= '0;
         tx_idx <= 3'h0;
      end else if (!pend) begin
         // A request while a reply is in flight is dropped
         if (rq_v) begin
            pend <= 1'b1;
            rep <= rq;
            tx_idx <= 3'h0;
         end
      end else if (!tx_busy && !tx_go) begin
         if (tx_idx == REPLY_BYTES) begin
            pend <= 1'b0;
         end else begin
            tx_go <= 1'b1;
         end
      end else if (tx_go) begin
         tx_idx <= tx_idx + 3'h1;
      end
   end

   // ----------------------------------------------------------------
   // Steady detector
   // ----------------------------------------------------------------
   logic [31:0] steady_cnt;
   logic armed;
   logic take;

   // Captures wait for an idle transmitter so no point report is lost
   assign take = cal_active && armed && !pend && !rq_v
      && steady_cnt == 32'(STEADY_CYC) && point_count < MAX_POINTS;

   always_ff @(posedge clk) begin
      if (sys_rst || !steady || !cal_active) begin
         steady_cnt <= 32'h0000_0000;
      end else if (steady_cnt != 32'(STEADY_CYC)) begin
         steady_cnt <= steady_cnt + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk) begin
      // Module must move and settle again before the next point
      if (sys_rst || !steady) begin
         armed <= 1'b1;
      end else if (take) begin
         armed <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Calibration sequencer
   // ----------------------------------------------------------------
   ccc_cal_t cst;
   logic [31:0] comp_cnt;
   logic [15:0] ref_heading;

   always_ff @(posedge clk) begin
      rq_v <= 1'b0;
      point_strobe <= 1'b0;
      if (sys_rst) begin
         cst <= CAL_IDLE;
         cal_active <= 1'b0;
         rq <= '0;
         comp_cnt <= 32'h0000_0000;
         point_count <= 6'h00;
         ref_heading <= 16'h0000;
         rel_heading <= 16'h0000;
         computing <= 1'b0;
         auto_mode <= 1'b1;
         use_factory <= 1'b1;
      end else if (cmd_valid) begin
         rq_v <= 1'b1;
         rq.cmd <= cmd_code | RSP_FLAG;
         rq.data <= RES_OK;
         case (cmd_code)
            CMD_AUTO: auto_mode <= 1'b1;
            CMD_MANUAL: auto_mode <= 1'b0;
            CMD_START: begin
               if (cst == CAL_COMPUTE) begin
                  rq.data <= RES_FAIL;
               end else begin
                  cst <= CAL_COLLECT;
                  cal_active <= 1'b1;
                  point_count <= 6'h00;
               end
            end
            CMD_STOP: begin
               if (cst == CAL_COLLECT && point_count != 6'h00) begin
                  cst <= CAL_COMPUTE;
                  cal_active <= 1'b0;
                  computing <= 1'b1;
                  comp_cnt <= 32'h0000_0000;
                  rq_v <= 1'b0;
               end else begin
                  rq.data <= RES_FAIL;
               end
            end
            CMD_SAVE: begin
               if (cst == CAL_DONE) begin
                  cst <= CAL_IDLE;
                  rq.data <= store_ok ? RES_OK : RES_FAIL;
                  use_factory <= !store_ok;
               end else begin
                  rq.data <= RES_FAIL;
               end
            end
            default: rq_v <= 1'b0;
         endcase
      end else if (cst == CAL_COMPUTE) begin
         if (comp_cnt == 32'(COMPUTE_CYC - 1)) begin
            cst <= CAL_DONE;
            computing <= 1'b0;
            rq_v <= 1'b1;
            rq.cmd <= CMD_STOP | RSP_FLAG;
            rq.data <= fit_quality;
         end else begin
            comp_cnt <= comp_cnt + 32'h0000_0001;
         end
      end else if (take) begin
         point_count <= point_count + 6'h01;
         point_strobe <= 1'b1;
         rq_v <= 1'b1;
         rq.cmd <= CMD_START | RSP_FLAG;
         rq.data <= {2'b00, point_count + 6'h01};
         if (point_count == 6'h00) begin
            ref_heading <= heading;
            rel_heading <= 16'h0000;
         end else begin
            rel_heading <= heading - ref_heading;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_frame_id: assert property (@(posedge clk) disable iff (sys_rst)
      tx_go && tx_idx == 3'h0 |-> tx_byte == FRAME_ID)
      else $error("reply frame does not open with identifier");
   chk_point_cap: assert property (@(posedge clk) disable iff (sys_rst)
      point_count <= MAX_POINTS)
      else $error("point count above fifty");
   chk_steady_wait: assert property (@(posedge clk) disable iff (sys_rst)
      point_strobe |-> $past(steady_cnt) == 32'(STEADY_CYC))
      else $error("point taken before steady time");
   chk_point_report: assert property (@(posedge clk) disable iff (sys_rst)
      point_strobe |-> rq_v && rq.cmd == (CMD_START | RSP_FLAG)
      && rq.data == {2'b00, point_count})
      else $error("point report missing or wrong count");
   chk_stop_compute: assert property (@(posedge clk) disable iff (sys_rst)
      cmd_valid && cmd_code == CMD_STOP && cal_active && point_count != 6'h00
      |=> computing && !rq_v)
      else $error("stop did not enter computing");
   chk_compute_len: assert property (@(posedge clk) disable iff (sys_rst)
      computing |-> comp_cnt < 32'(COMPUTE_CYC))
      else $error("computing ran too long");
   chk_refuse_save: assert property (@(posedge clk) disable iff (sys_rst)
      cmd_valid && cmd_code == CMD_SAVE && cst != CAL_DONE
      |=> rq_v && rq.data == RES_FAIL)
      else $error("save without result not refused");
   chk_save_factory: assert property (@(posedge clk) disable iff (sys_rst)
      cmd_valid && cmd_code == CMD_SAVE && cst == CAL_DONE
      |=> use_factory == !$past(store_ok))
      else $error("factory fallback wrong after save");
   chk_bad_sum: assert property (@(posedge clk) disable iff (sys_rst)
      rx_valid && pst == P_SUM && rx_byte != f_sum |=> !cmd_valid)
      else $error("frame with bad checksum accepted");
   chk_start_ack: assert property (@(posedge clk) disable iff (sys_rst)
      cmd_valid && cmd_code == CMD_START && cst != CAL_COMPUTE
      |=> cal_active && point_count == 6'h00 && rq.data == RES_OK)
      else $error("start not acknowledged");
endmodule // ccc_calib
`default_nettype wire

// ### bench/ccc_host.sv
// Host controller model that frames commands and collects replies
`timescale 1ns/1ps
`default_nettype none
module ccc_host import ccc_pkg::*; #(
   parameter int WAIT_MAX = 200000,
   parameter int BIT_LEN = int'(BIT_CYC)
) (
   input wire logic clk,
   input wire logic dev_txd,
   output logic dev_rxd
);
   // ----------------------------------------------------------------
   // Serial line, 8N1, idle high between frames
   // ----------------------------------------------------------------
   initial dev_rxd = 1'b1;
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(negedge clk);
         dev_rxd = f[i];
         repeat (BIT_LEN - 1) @(negedge clk);
      end
   endtask
   task automatic send_frame(input logic [7:0] cmd, input logic bad);
      logic [7:0] sum;
      sum = LEN_MIN + DEV_ADDR + cmd;
      send_byte(FRAME_ID);
      send_byte(LEN_MIN);
      send_byte(DEV_ADDR);
      send_byte(cmd);
      send_byte(bad ? sum ^ 8'h01 : sum);
   endtask
   // Bounded wait for a start bit, then centre sampling, LSB first
   task automatic recv_byte(output logic [7:0] b, output logic got);
      int n;
      n = 0;
      got = 1'b0;
      b = 8'h00;
      while (dev_txd !== 1'b0 && n < WAIT_MAX) begin
         @(posedge clk);
         n++;
      end
      if (dev_txd === 1'b0) begin
         got = 1'b1;
         repeat (BIT_LEN / 2) @(posedge clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_LEN) @(posedge clk);
            b[i] = dev_txd;
         end
         repeat (BIT_LEN) @(posedge clk);
         if (dev_txd !== 1'b1) got = 1'b0;
      end
   endtask
   // Got is set only for a whole, well-formed reply frame
   task automatic recv_reply(output ccc_reply_t r, output logic got);
      logic [7:0] b [6];
      logic g;
      got = 1'b1;
      for (int i = 0; i < 6; i++) b[i] = 8'h00;
      for (int i = 0; i < 6; i++) begin
         recv_byte(b[i], g);
         if (g !== 1'b1) begin
            got = 1'b0;
            break;
         end
      end
      r = {b[3], b[4]};
      if (b[0] !== FRAME_ID || b[1] !== LEN_REPLY) got = 1'b0;
      if (b[2] !== DEV_ADDR) got = 1'b0;
      if (b[5] !== 8'(b[1] + b[2] + b[3] + b[4])) got = 1'b0;
   endtask
   // Reply may start before our own stop bit ends, so listen meanwhile
   task automatic xact(input logic [7:0] cmd, input logic bad,
                       output ccc_reply_t r, output logic got);
      fork
         send_frame(cmd, bad);
         recv_reply(r, got);
      join
   endtask
endmodule // ccc_host
`default_nettype wire

// ### bench/ccc_calib_tb.sv
// Self-checking testbench of the calibration command interpreter
`timescale 1ns/1ps
`default_nettype none
module ccc_calib_tb import ccc_pkg::*;;
   localparam int unsigned STEADY = 200;
   localparam int unsigned COMPUTE = 300;
   localparam int LIMIT = 90000;
   logic clk, sys_rst, rxd, steady, store_ok, txd, point_strobe;
   logic cal_active, computing, auto_mode, use_factory, got;
   logic [15:0] heading, rel_heading, last_rel;
   logic [7:0] fit_quality;
   logic [5:0] point_count;
   int errors, n_compared, cycles, comp_cyc, n_strobe, strobe_cyc;
   ccc_reply_t r;
   ccc_calib #(.STEADY_CYC(STEADY), .COMPUTE_CYC(COMPUTE),
      .BIT_LEN(12'h010)) dut (
      .clk(clk), .sys_rst(sys_rst), .rxd(rxd), .steady(steady),
      .heading(heading), .fit_quality(fit_quality), .store_ok(store_ok),
      .txd(txd), .point_strobe(point_strobe), .rel_heading(rel_heading),
      .point_count(point_count), .cal_active(cal_active),
      .computing(computing), .auto_mode(auto_mode),
      .use_factory(use_factory));
   ccc_host #(.WAIT_MAX(4000), .BIT_LEN(16)) host (.clk(clk),
      .dev_txd(txd), .dev_rxd(rxd));
   // ----------------------------------------------------------------
   // Clock, watchers and hang guard
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (computing === 1'b1) comp_cyc++;
      if (point_strobe === 1'b1) begin
         n_strobe++;
         strobe_cyc = cycles;
         last_rel = rel_heading;
      end
      if (cycles >= LIMIT) begin
         errors++;
         $display("[FAIL] %0t run exceeded its cycle budget", $time);
         tally_and_finish();
      end
   end
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                        input string msg);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t %s seen %h exp %h", $time, msg, seen, exp);
      end
   endtask
   task automatic xchk(input logic [7:0] cmd, input logic [7:0] data);
      host.xact(cmd, 1'b0, r, got);
      check(16'(got), 16'h0001, "reply frame");
      check(16'(r.cmd), 16'(cmd | RSP_FLAG), "reply command");
      check(16'(r.data), 16'(data), "reply data");
   endtask
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_refuse();
      check(16'({txd, auto_mode, use_factory, cal_active, computing}),
            16'h001C, "reset state");
      xchk(CMD_STOP, RES_FAIL);
      xchk(CMD_SAVE, RES_FAIL);
      check(16'(use_factory), 16'h0001, "factory kept");
      $display("test refuse done");
   endtask
   task automatic t_bad_frame();
      host.xact(CMD_MANUAL, 1'b1, r, got);
      check(16'(got), 16'h0000, "bad sum answered");
      check(16'(auto_mode), 16'h0001, "bad sum acted");
      $display("test bad frame done");
   endtask
   task automatic t_modes();
      xchk(CMD_MANUAL, RES_OK);
      check(16'(auto_mode), 16'h0000, "manual mode");
      xchk(CMD_AUTO, RES_OK);
      check(16'(auto_mode), 16'h0001, "auto mode");
      $display("test modes done");
   endtask
   // Held steady, captured, reported with the running count
   task automatic point(input logic [15:0] h, input logic [15:0] rel,
                        input int k);
      int rise;
      @(negedge clk);
      heading = h;
      steady = 1'b1;
      rise = cycles;
      host.recv_reply(r, got);
      @(negedge clk);
      steady = 1'b0;
      check(16'(got), 16'h0001, "point frame");
      check(16'(r.cmd), 16'(CMD_START | RSP_FLAG), "point cmd");
      check(16'(r.data), 16'(k), "point data");
      check(16'(n_strobe), 16'(k), "strobes");
      check(16'(strobe_cyc - rise >= STEADY &&
                strobe_cyc - rise <= STEADY + 4), 16'h0001, "hold");
      check(last_rel, rel, "relative heading");
      check(16'(point_count), 16'(k), "point count");
   endtask
   // Whole run: start, brief wobble, twelve points, stop, save
   task automatic t_run(input logic ok, input logic [7:0] q);
      n_strobe = 0;
      xchk(CMD_START, RES_OK);
      check(16'({cal_active, point_count}), 16'h0040, "collect");
      @(negedge clk);
      steady = 1'b1;
      repeat (STEADY / 2) @(negedge clk);
      steady = 1'b0;
      repeat (STEADY * 2) @(negedge clk);
      check(16'(n_strobe), 16'h0000, "short hold captured");
      // Host collects the minimum twelve points before it stops
      for (int k = 1; k <= int'(MIN_POINTS); k++) begin
         point(16'h1234 + 16'(k - 1) * 16'h3F00,
               16'(k - 1) * 16'h3F00, k);
      end
      fit_quality = q;
      store_ok = ok;
      comp_cyc = 0;
      xchk(CMD_STOP, q);
      check(16'(comp_cyc >= COMPUTE && comp_cyc <= COMPUTE + 8),
            16'h0001, "compute time");
      check(16'(cal_active), 16'h0000, "collect ended");
      xchk(CMD_SAVE, ok ? RES_OK : RES_FAIL);
      check(16'(use_factory), 16'(!ok), "factory data");
      $display("test run done");
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      sys_rst = 1'b1;
      steady = 1'b0;
      heading = 16'h0000;
      fit_quality = 8'h00;
      store_ok = 1'b0;
      repeat (16) @(negedge clk);
      sys_rst = 1'b0;
      t_refuse();
      t_bad_frame();
      t_modes();
      t_run(1'b0, 8'h3C);
      t_run(1'b1, 8'h5A);
      xchk(CMD_SAVE, RES_FAIL);
      tally_and_finish();
   end
endmodule // ccc_calib_tb
`default_nettype wire
